// ===== logic/pc_return_stack.sv
// Program counter sequencer and circular return stack of a small core.
// Assumes decoder strobes are single-cycle, same-clock, one instruction each;
// software reaches the low byte and the upper latch over AHB-Lite.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module pc_return_stack
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter logic [PC_WIDTH-1:0] VECTOR = VECTOR_ADDR
) (
  input wire logic i_clock,                       // 100 MHz core clock
  input wire logic i_rst_b,                       // Async reset, active low
  // AHB-Lite slave
  input wire logic i_hsel,                        // Slave select
  input wire logic [BUS_WIDTH-1:0] i_haddr,       // Byte address
  input wire logic [1:0] i_htrans,                // Transfer type
  input wire logic i_hwrite,                      // Write when high
  input wire logic [2:0] i_hsize,                 // Transfer size
  input wire logic [BUS_WIDTH-1:0] i_hwdata,      // Write data
  input wire logic i_hready,                      // Bus ready
  output logic [BUS_WIDTH-1:0] o_hrdata,          // Read data
  output logic o_hreadyout,                       // Always ready
  output logic o_hresp,                           // Always OKAY
  // Core decoder
  input wire logic i_fetch,                       // Instruction fetched
  input wire logic i_jump_op,                     // Jump executed
  input wire logic i_call_op,                     // Call executed
  input wire logic i_return_op,                   // Plain return
  input wire logic i_return_with_literal_op,      // Return with literal
  input wire logic i_return_from_interrupt_op,    // Return from interrupt
  input wire logic i_int_vector,                  // Interrupt branch taken
  input wire logic [TARGET_WIDTH-1:0] i_target,   // Call or jump operand
  output logic [PC_WIDTH-1:0] o_pc                // Next fetch address
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  logic rst_n;
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] next_pc;
  logic [LATCH_WIDTH-1:0] latch;
  logic [LATCH_WIDTH-1:0] next_latch;
  logic [PW-1:0] ptr;
  logic [PW-1:0] next_ptr;
  logic [PW-1:0] rd_slot;
  logic [PC_WIDTH-1:0] top;
  logic push;
  logic any_return;
  pc_op_t op;
  logic addr_ok;
  logic wr_low;
  logic wr_latch;
  logic rd_low;
  logic next_wr_low;
  logic next_wr_latch;
  logic next_rd_low;
  logic [BUS_WIDTH-1:0] next_hrdata;

  // ==========================================================================
  // Reset release
  rst_sync u_rst_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .o_rst_b(rst_n)
  );

  // ==========================================================================
  // AHB-Lite address phase: only the two registers decode, others read zero
  always_comb begin
    addr_ok = i_hsel && i_hready && i_htrans[HTRANS_ACTIVE];
    next_wr_low = addr_ok && i_hwrite &&
                  (i_haddr[DEC_WIDTH-1:0] == OFF_PC_LOW_BYTE);
    next_wr_latch = addr_ok && i_hwrite &&
                    (i_haddr[DEC_WIDTH-1:0] == OFF_PC_UPPER_LATCH);
    next_rd_low = addr_ok && !i_hwrite &&
                  (i_haddr[DEC_WIDTH-1:0] == OFF_PC_LOW_BYTE);
  end

  // Data phase flags; writes land at the end of the data phase
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_low <= 1'b0;
      wr_latch <= 1'b0;
      rd_low <= 1'b0;
    end else begin
      wr_low <= next_wr_low;
      wr_latch <= next_wr_latch;
      rd_low <= next_rd_low;
    end
  end

  // ==========================================================================
  // Pick one counter update; vectoring outranks returns, calls and jumps
  // A low-byte write that meets a jump, call, return or vectoring strobe is dropped without notice; it wins over a fetch.
  always_comb begin
    any_return = i_return_op || i_return_with_literal_op ||
                 i_return_from_interrupt_op;
    op = OP_HOLD;
    if (i_int_vector) begin
      op = OP_VEC;
    end else if (any_return) begin
      op = OP_POP;
    end else if (i_call_op) begin
      op = OP_CALL;
    end else if (i_jump_op) begin
      op = OP_JUMP;
    end else if (wr_low) begin
      op = OP_LOW_WRITE;
    end else if (i_fetch) begin
      op = OP_STEP;
    end
  end

  // ==========================================================================
  // Counter, latch and stack pointer next values
  always_comb begin
    next_pc = pc;
    next_ptr = ptr;
    push = 1'b0;
    unique case (op)
      OP_HOLD: begin
        next_pc = pc;
      end
      OP_STEP: begin
        next_pc = pc + PC_ONE;
      end
      OP_LOW_WRITE: begin
        next_pc = {latch, i_hwdata[LOW_WIDTH-1:0]};
      end
      OP_JUMP: begin
        next_pc = {latch[LATCH_JUMP_HI:LATCH_JUMP_LO], i_target};
      end
      OP_CALL: begin
        next_pc = {latch[LATCH_JUMP_HI:LATCH_JUMP_LO], i_target};
        push = 1'b1;
        next_ptr = ptr + PTR_ONE;
      end
      OP_VEC: begin
        next_pc = VECTOR;
        push = 1'b1;
        next_ptr = ptr + PTR_ONE;
      end
      OP_POP: begin
        next_pc = top;
        next_ptr = ptr - PTR_ONE;
      end
    endcase
  end

  // Latch changes only on a software write, never on push or pop
  always_comb begin
    next_latch = latch;
    if (wr_latch) begin
      next_latch = i_hwdata[LATCH_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // State registers
  // Pointer restarts at slot zero; entries above it keep stale contents.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
      latch <= LATCH_RESET;
      ptr <= '0;
    end else begin
      pc <= next_pc;
      latch <= next_latch;
      ptr <= next_ptr;
    end
  end

  // ==========================================================================
  // Return stack: the read port always tracks the entry below the pointer,
  // so a pop costs no extra cycle. No pointer or status leaves the block.
  always_comb begin
    rd_slot = next_ptr - PTR_ONE;
  end

  stack_ram #(
    .DEPTH(DEPTH),
    .WIDTH(PC_WIDTH),
    .AW(PW)
  ) u_stack (
    .i_clock(i_clock),
    .i_rst_b(rst_n),
    .i_we(push),
    .i_waddr(ptr),
    .i_wdata(pc),
    .i_raddr(rd_slot),
    .o_rdata(top)
  );

  // ==========================================================================
  // Read data built from next values so it matches state in the data phase
  // A read right behind a write to the same register already sees the new value.
  always_comb begin
    next_hrdata = '0;
    if (addr_ok && !i_hwrite) begin
      if (i_haddr[DEC_WIDTH-1:0] == OFF_PC_LOW_BYTE) begin
        next_hrdata[LOW_WIDTH-1:0] = next_pc[LOW_WIDTH-1:0];
      end else if (i_haddr[DEC_WIDTH-1:0] == OFF_PC_UPPER_LATCH) begin
        next_hrdata[LATCH_WIDTH-1:0] = next_latch;
      end
    end
  end

  // Bus outputs; zero wait states, so ready and response are constant
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= HRESP_OKAY;
    end else begin
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= HRESP_OKAY;
    end
  end

  assign o_pc = pc;

  // ==========================================================================
  // Assertions
  // The pointer never leaves the block, so its behaviour is checked here;
  // the bench sees it only through the return addresses.
  AST_RESET_CLEAR: assert property (
    @(posedge i_clock) $rose(rst_n) |-> (o_pc == PC_RESET)
  ) else $error("counter not zero at reset release");

  AST_STEP: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_STEP) |=> (o_pc == $past(o_pc) + PC_ONE)
  ) else $error("fetch did not advance counter by one");

  AST_LOW_WRITE: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_LOW_WRITE) |=>
      (o_pc == {$past(latch), $past(i_hwdata[LOW_WIDTH-1:0])})
  ) else $error("low byte write did not load latch into high part");

  AST_JUMP: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_JUMP || op == OP_CALL) |=>
      (o_pc[PC_WIDTH-1:TARGET_WIDTH] == $past(latch[LATCH_JUMP_HI:LATCH_JUMP_LO]))
      && (o_pc[TARGET_WIDTH-1:0] == $past(i_target))
  ) else $error("jump target not built from latch and operand");

  AST_PUSH_POP: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_CALL) ##1 (op == OP_POP) |=> (o_pc == $past(o_pc, 2))
  ) else $error("return after call did not restore the return address");

  AST_POP_PTR: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_POP) |=> (ptr == $past(ptr) - PTR_ONE) && (o_pc == $past(top))
  ) else $error("pop did not take top entry and step pointer back");

  AST_LATCH_KEEP: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (push || op == OP_POP) && !wr_latch |=> $stable(latch)
  ) else $error("latch changed on push or pop");

  AST_VECTOR: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_int_vector |=> (o_pc == VECTOR) && (ptr == $past(ptr) + PTR_ONE)
  ) else $error("vectoring did not branch and push");

  AST_READ_LOW: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    rd_low |-> (o_hrdata == {{(BUS_WIDTH-LOW_WIDTH){1'b0}}, o_pc[LOW_WIDTH-1:0]})
  ) else $error("low byte read does not show the counter");

  AST_NO_STRAY_PUSH: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    !(i_call_op || i_int_vector || any_return) |=> (ptr == $past(ptr))
  ) else $error("stack pointer moved without call, return or vectoring");

  AST_READY: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    o_hreadyout && (o_hresp == HRESP_OKAY)
  ) else $error("slave not ready or not OKAY");

  AST_LATCH_WRITE: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    wr_latch |=> (latch == $past(i_hwdata[LATCH_WIDTH-1:0]))
  ) else $error("latch write did not land");

  AST_CALL_PUSH: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_CALL) |=> (ptr == $past(ptr) + PTR_ONE)
  ) else $error("call did not advance the stack pointer");

  AST_PUSH_DATA: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    push |=> (top == $past(o_pc))
  ) else $error("pushed entry is not the counter at the push");

  AST_WRAP: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    push && (ptr == PW'(DEPTH - 1)) |=> (ptr == '0)
  ) else $error("stack pointer did not wrap to the first slot");

  AST_HOLD: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_HOLD) |=> (o_pc == $past(o_pc)) && (ptr == $past(ptr))
  ) else $error("counter or pointer moved with no update");

  AST_HRDATA_IDLE: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    !(addr_ok && !i_hwrite) |=> (o_hrdata == '0)
  ) else $error("read data not zero outside a read data phase");

  // Main scenarios
  COV_CALL_RETURN: cover property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_CALL) ##[1:20] (op == OP_POP)
  );

  COV_WRAP: cover property (
    @(posedge i_clock) disable iff (!rst_n)
    push && (ptr == PW'(DEPTH - 1))
  );

  COV_LOW_WRITE: cover property (
    @(posedge i_clock) disable iff (!rst_n)
    wr_latch ##[1:10] (op == OP_LOW_WRITE)
  );

  COV_VECTOR_RETURN: cover property (
    @(posedge i_clock) disable iff (!rst_n)
    i_int_vector ##[1:20] i_return_from_interrupt_op
  );

  COV_POP_WRAP: cover property (
    @(posedge i_clock) disable iff (!rst_n)
    (op == OP_POP) && (ptr == '0)
  );

endmodule
`default_nettype wire

// ===== include/pc_stack_pkg.sv
// Constants, types and register map of the program counter and return stack.
// Assumes one 100 MHz clock shared by the core decoder and the AHB-Lite bus.
// Notes on behaviour
// - Program counter is 13 bits wide, covering all program memory.
// - Low byte of the program counter is a software read/write register.
// - Counter bits 12..8 are invisible to software; software sets them only through the latch.
// - Any reset clears the whole program counter to zero.
// - Writing the low byte loads latch bits 4..0 into the counter high part.
// - Call and jump take counter bits 12..11 from latch bits 4..3.
// - Return stack holds eight entries of thirteen bits each.
// - Stack and its pointer are outside all address spaces, not accessible.
// - Call and interrupt vectoring push the return address.
// - Return, return-with-literal and return-from-interrupt pop into the counter.
// - Pushes and pops leave the upper-address latch unchanged.
// - Stack is circular; the ninth push overwrites the first.
// - No overflow or underflow status is provided; wrapping is silent.
// - Only call, the three returns and vectoring push or pop.

package pc_stack_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_WIDTH = 13;
  localparam int LOW_WIDTH = 8;
  localparam int LATCH_WIDTH = 5;
  localparam int TARGET_WIDTH = 11;
  localparam int STACK_DEPTH = 8;
  localparam int BUS_WIDTH = 32;
  localparam int DEC_WIDTH = 12;

  // ==========================================================================
  // Field positions
  localparam int LATCH_JUMP_HI = 4;
  localparam int LATCH_JUMP_LO = 3;
  localparam int HTRANS_ACTIVE = 1;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [DEC_WIDTH-1:0] OFF_PC_LOW_BYTE = 12'h000;
  localparam logic [DEC_WIDTH-1:0] OFF_PC_UPPER_LATCH = 12'h004;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
  localparam logic [LATCH_WIDTH-1:0] LATCH_RESET = 5'h00;
  localparam logic [PC_WIDTH-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_WIDTH-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic HRESP_OKAY = 1'b0;

  // ==========================================================================
  // Counter update selection, one-hot
  typedef enum logic [6:0] {
    OP_HOLD = 7'h01,
    OP_STEP = 7'h02,
    OP_LOW_WRITE = 7'h04,
    OP_JUMP = 7'h08,
    OP_CALL = 7'h10,
    OP_VEC = 7'h20,
    OP_POP = 7'h40
  } pc_op_t;

endpackage

// ===== logic/rst_sync.sv
// Two-stage reset release synchroniser.
// Assumes an active-low asynchronous reset from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module rst_sync (
  input wire logic i_clock,  // Core clock
  input wire logic i_rst_b,  // Raw reset, active low
  output logic o_rst_b       // Released reset, active low
);

  logic stage1;

  // ==========================================================================
  // Assert at once, release after two edges to avoid metastable release
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= 1'b0;
      o_rst_b <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      o_rst_b <= stage1;
    end
  end

endmodule
`default_nettype wire

// ===== logic/stack_ram.sv
// Small return-stack memory with a registered read port and write bypass.
// Assumes the owner never pushes and pops in the same cycle.
`timescale 1ns/100ps
`default_nettype none

module stack_ram #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clock,               // Core clock
  input wire logic i_rst_b,               // Synchronised reset, active low
  input wire logic i_we,                  // Write strobe
  input wire logic [AW-1:0] i_waddr,      // Write slot
  input wire logic [WIDTH-1:0] i_wdata,   // Write data
  input wire logic [AW-1:0] i_raddr,      // Read slot for next cycle
  output logic [WIDTH-1:0] o_rdata        // Registered read data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  // ==========================================================================
  // Bypass so a pop right after a push sees the fresh entry
  always_comb begin
    next_rdata = mem[i_raddr];
    if (i_we && (i_waddr == i_raddr)) begin
      next_rdata = i_wdata;
    end
  end

  // Storage has no reset: an empty stack simply returns old contents
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== tb/core_decoder_model.sv
// Core decoder stand-in: turns one opcode per cycle into decoder strobes.
// Assumes the bench changes i_op right after a rising edge, one op at a time.
`timescale 1ns/100ps
`default_nettype none

module core_decoder_model
  import pc_stack_pkg::*;
(
  input wire logic [2:0] i_op,                // 0 none,1 fetch,2 jump,3 call
  input wire logic [TARGET_WIDTH-1:0] i_tgt,  // 4 ret,5 ret lit,6 ret int,7 vector
  output logic o_fetch,                       // Fetch strobe
  output logic o_jump,                        // Jump strobe
  output logic o_call,                        // Call strobe
  output logic o_ret,                         // Plain return strobe
  output logic o_ret_lit,                     // Return with literal strobe
  output logic o_ret_int,                     // Return from interrupt strobe
  output logic o_vec,                         // Interrupt vectoring strobe
  output logic [TARGET_WIDTH-1:0] o_target    // Operand, only meaningful with jump or call
);
  // ==========================================================================
  // Decode: no push or pop strobe exists apart from call, returns and vectoring
  always_comb begin
    o_fetch = (i_op == 3'h1);
    o_jump = (i_op == 3'h2);
    o_call = (i_op == 3'h3);
    o_ret = (i_op == 3'h4);
    o_ret_lit = (i_op == 3'h5);
    o_ret_int = (i_op == 3'h6);
    o_vec = (i_op == 3'h7);
    // Operand garbled outside jump and call so a stale sample shows up
    o_target = (o_jump || o_call) ? i_tgt : ~i_tgt;
  end
endmodule
`default_nettype wire

// ===== tb/program_counter_and_return_stack_tb_top.sv
// Self-checking bench of the program counter and return stack.
// Assumes zero-wait AHB-Lite slave and the decoder model in front of the strobes.
`timescale 1ns/100ps
`default_nettype none

module program_counter_and_return_stack_tb_top
  import pc_stack_pkg::*;
;
  typedef struct {
    logic [2:0] op;
    logic [TARGET_WIDTH-1:0] tgt;
    logic [PC_WIDTH-1:0] pc;
  } row_t;

  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] op = 3'h0;
  logic [TARGET_WIDTH-1:0] tgt = 11'h000;
  logic s_fetch, s_jump, s_call, s_ret, s_ret_lit, s_ret_int, s_vec;
  logic [TARGET_WIDTH-1:0] s_target;
  logic [PC_WIDTH-1:0] pc;
  logic [31:0] q;
  int n_fail = 0;
  int n_compared = 0;
  row_t rows [11];

  // ==========================================================================
  // Clock and instances
  initial begin
    forever #5 i_clock = ~i_clock;
  end

  core_decoder_model dec (.i_op(op), .i_tgt(tgt), .o_fetch(s_fetch), .o_jump(s_jump),
    .o_call(s_call), .o_ret(s_ret), .o_ret_lit(s_ret_lit), .o_ret_int(s_ret_int),
    .o_vec(s_vec), .o_target(s_target));

  pc_return_stack dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_fetch(s_fetch), .i_jump_op(s_jump), .i_call_op(s_call),
    .i_return_op(s_ret), .i_return_with_literal_op(s_ret_lit),
    .i_return_from_interrupt_op(s_ret_int), .i_int_vector(s_vec), .i_target(s_target),
    .o_pc(pc));

  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Waits for hready at an edge; a stuck bus ends the run instead of hanging
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
  endtask

  // One single AHB-Lite word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  // Issues one decoder op and checks the counter after the taking edge
  task automatic step(input logic [2:0] o, input logic [10:0] t, input logic [12:0] e);
    op <= o;
    tgt <= t;
    @(posedge i_clock);
    #1;
    chk("pc", {19'h0, e}, {19'h0, pc});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    // Latch holds 5'h1A, so jumps and calls take 2'b11 on top
    rows = '{'{3'h1, 11'h000, 13'h0001}, '{3'h1, 11'h000, 13'h0002},
      '{3'h2, 11'h7FF, 13'h1FFF}, '{3'h1, 11'h000, 13'h0000},
      '{3'h1, 11'h000, 13'h0001}, '{3'h3, 11'h123, 13'h1923},
      '{3'h1, 11'h000, 13'h1924}, '{3'h7, 11'h000, 13'h0004},
      '{3'h6, 11'h000, 13'h1924}, '{3'h5, 11'h000, 13'h0001},
      '{3'h0, 11'h000, 13'h0001}};
    repeat (4) @(posedge i_clock);
    chk("pc in reset", 32'h0, {19'h0, pc});
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_clock);
    #1;
    chk("pc after reset", 32'h0, {19'h0, pc});
    bus(1'b1, {20'h0, OFF_PC_UPPER_LATCH}, 32'hFFFF_FFFA);
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].tgt, rows[i].pc);
    end
    // Low-byte write pulls the whole latch into the high part
    bus(1'b1, {20'h0, OFF_PC_LOW_BYTE}, 32'h1234_565C);
    #1;
    chk("pc low write", 32'h1A5C, {19'h0, pc});
    bus(1'b1, 32'h0000_0008, 32'h0000_0011);
    bus(1'b0, {20'h0, OFF_PC_LOW_BYTE}, 32'h0);
    chk("low byte", 32'h5C, q);
    // Ten calls into an eight-deep stack, then nine pops across all returns
    for (int k = 0; k < 10; k++) begin
      step(3'h3, 11'(k), 13'h1800 | 13'(k));
    end
    for (int j = 0; j < 8; j++) begin
      step(3'(4 + j % 3), 11'h000, 13'h1800 | 13'(8 - j));
    end
    step(3'h4, 11'h000, 13'h1808);
    op <= 3'h0;
    bus(1'b0, {20'h0, OFF_PC_UPPER_LATCH}, 32'h0);
    chk("latch", 32'h1A, q);
    bus(1'b0, {20'h0, OFF_PC_LOW_BYTE}, 32'h0);
    chk("low byte", 32'h08, q);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk("unmapped", 32'h0, q);
    // Mid-run reset clears the counter and the latch
    i_rst_b <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("pc mid reset", 32'h0, {19'h0, pc});
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_clock);
    bus(1'b0, {20'h0, OFF_PC_UPPER_LATCH}, 32'h0);
    chk("latch reset", {27'h0, LATCH_RESET}, q);
    end_sim();
  end
endmodule
`default_nettype wire
